// ---- arq_pkg.sv ----
// Constants, encodings and register map for the asynchronous receive packet queue.
// Assumes an APB master with 32-bit data; a receive source presents decoded packet fields.
// Behaviour
// RULE1: Store foreign requests, skip agent-addressed ones
// RULE2: Store responses to transmit-queue packets
// RULE3: Host reads quadlets at offset 80h
// RULE4: Status and configuration at offset 30h
// RULE5: Token quadlet first with status, speed, ack
// RULE6: Quadlet two: destination ID, label, retry, tcode, priority
// RULE7: Quadlet packets: source ID and rcode third
// RULE8: Quadlet data only for writes, read responses
// RULE9: Block packets carry 48-bit offset
// RULE10: Block data only for writes, read responses
// RULE11: Status 0h complete or split pending
// RULE12: Status 1h for no-acknowledge packet
// RULE13: Status 2h for other acknowledges; the code gives 0h for busy acks 4h-6h
// RULE14: Status 3h for missing or bad ack
// RULE15: Status 4h for invalid next pointer
// RULE16: Status 5h for forwarded next pointer
// RULE17: Status 7h on retry time-out
// RULE18: Status 8h for incomplete response code
// RULE19: Speed 00/01/10 for 100/200/400 Mbps
// RULE20: Identifiers are 10-bit bus, 6-bit node
// RULE21: Stored priority bits are zero
// RULE22: Read out in arrival order
// RULE23: Status is a four-bit token field
package arq_pkg;
	localparam logic [11:0] ADDR_SPLIT = 12'h008;
	localparam logic [11:0] ADDR_STAT = 12'h030;
	localparam logic [11:0] ADDR_PORT = 12'h080;
	// Token, quadlet two and quadlet three field layout
	localparam int TOK_STAT_LSB = 28;
	localparam int TOK_SPD_LSB = 16;
	localparam int TOK_ACK_LSB = 0;
	localparam int Q2_PRI_LSB = 0;
	localparam int Q3_RC_LSB = 12;
	// Status codes
	localparam logic [3:0] ST_DONE = 4'h0;
	localparam logic [3:0] ST_NOACK = 4'h1;
	localparam logic [3:0] ST_BADACK = 4'h2;
	localparam logic [3:0] ST_MISSACK = 4'h3;
	localparam logic [3:0] ST_BADNEXT = 4'h4;
	localparam logic [3:0] ST_FWDNEXT = 4'h5;
	localparam logic [3:0] ST_RETRY = 4'h7;
	localparam logic [3:0] ST_RCODE = 4'h8;
	// Acknowledge and response codes
	localparam logic [3:0] ACK_COMPLETE = 4'h1;
	localparam logic [3:0] ACK_PENDING = 4'h2;
	localparam logic [3:0] ACK_BUSY_X = 4'h4;
	localparam logic [3:0] ACK_BUSY_A = 4'h5;
	localparam logic [3:0] ACK_BUSY_B = 4'h6;
	localparam logic [3:0] RCODE_COMPLETE = 4'h0;
	// Receive event kinds
	localparam logic [2:0] EV_ACK = 3'h0;
	localparam logic [2:0] EV_NOACK = 3'h1;
	localparam logic [2:0] EV_ACKERR = 3'h2;
	localparam logic [2:0] EV_BADNEXT = 3'h3;
	localparam logic [2:0] EV_FWDNEXT = 3'h4;
	localparam logic [2:0] EV_RETRY = 3'h5;
	// Status register fields
	localparam int SR_EN_BIT = 0;
	localparam int SR_EMPTY_BIT = 1;
	localparam int SR_FULL_BIT = 2;
	localparam int SR_DROP_BIT = 3;
	localparam int SR_CNT_LSB = 8;
	localparam logic [31:0] SR_RESET = 32'h0000_0001;
	// Formatter states, Gray along the header path
	typedef enum logic [2:0] {
		ARQ_IDLE = 3'b000,
		ARQ_Q1 = 3'b001,
		ARQ_Q2 = 3'b011,
		ARQ_Q3 = 3'b010,
		ARQ_Q4 = 3'b110,
		ARQ_Q5 = 3'b111,
		ARQ_DATA = 3'b101
	} arq_state_e;
endpackage : arq_pkg

// ---- arq_store.sv ----
// Flip-flop quadlet store, read in arrival order.
// Assumes the writer checks full and the reader checks empty.
`timescale 1ns/100ps
module arq_store #(
	parameter int DEPTH = 64,
	parameter int AW = 6
) (
	input wire logic sys_clk_i, // Clock
	input wire logic rst_n_i, // Async reset, low
	input wire logic wr_i, // Push quadlet
	input wire logic [31:0] wdata_i, // Pushed quadlet
	input wire logic rd_i, // Pop quadlet
	output logic [31:0] rdata_o, // Head quadlet
	output logic [AW:0] count_o // Fill level
);
	logic [31:0] mem_q [DEPTH];
	logic [AW-1:0] wp_q;
	logic [AW-1:0] rp_q;

	// Storage write
	always_ff @(posedge sys_clk_i) begin
		if (wr_i) begin
			mem_q[wp_q] <= wdata_i;
		end
	end

	// Pointers; wrap by width, so depth must be a power of two
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wp_q <= '0;
			rp_q <= '0;
			count_o <= '0;
		end else begin
			wp_q <= wp_q + AW'(wr_i);
			rp_q <= rp_q + AW'(rd_i); // see RULE22
			count_o <= count_o + (AW+1)'(wr_i) - (AW+1)'(rd_i);
		end
	end

	assign rdata_o = mem_q[rp_q];
endmodule : arq_store

// ---- arq_top.sv ----
// Asynchronous receive packet queue: packet formatter, store and APB slave.
// Assumes receive source holds the packet fields stable while rx_valid_i is high.
`timescale 1ns/100ps
module arq_top #(
	parameter int DEPTH = 64,
	parameter int AW = 6
) (
	input wire logic sys_clk_i, // Clock, 250 MHz
	input wire logic rst_n_i, // Async reset, low
	input wire logic psel_i, // APB select
	input wire logic penable_i, // APB enable
	input wire logic pwrite_i, // APB direction
	input wire logic [11:0] paddr_i, // APB address
	input wire logic [31:0] pwdata_i, // APB write data
	output logic [31:0] prdata_o, // APB read data
	output logic pready_o, // APB ready
	output logic pslverr_o, // APB error
	input wire logic rx_valid_i, // Packet offered
	output logic rx_ready_o, // Packet taken, pulse
	input wire logic rx_is_resp_i, // Response to our transmit
	input wire logic rx_to_agent_i, // Request for on-chip agent
	input wire logic rx_block_i, // Block format
	input wire logic rx_has_data_i, // Write request or read response
	input wire logic [2:0] rx_event_i, // Status event kind
	input wire logic [3:0] rx_ack_i, // Acknowledge code
	input wire logic [1:0] rx_speed_i, // Receive speed
	input wire logic [9:0] rx_dst_bus_i, // Destination bus
	input wire logic [5:0] rx_dst_node_i, // Destination node
	input wire logic [9:0] rx_src_bus_i, // Source bus
	input wire logic [5:0] rx_src_node_i, // Source node
	input wire logic [5:0] rx_tlabel_i, // Transaction label
	input wire logic [1:0] rx_retry_code_i, // Retry code
	input wire logic [3:0] rx_tcode_i, // Transaction code
	input wire logic [3:0] rx_rcode_i, // Response code
	input wire logic [47:0] rx_offset_i, // Destination offset
	input wire logic [15:0] rx_len_i, // Block length word
	input wire logic [15:0] rx_ext_tcode_i, // Extended tcode
	input wire logic [7:0] rx_nquad_i, // Data quadlets
	input wire logic [31:0] rx_data_i, // Current data quadlet
	output logic rx_data_take_o, // Data quadlet consumed, pulse
	output logic split_en_o // Split transaction enable
);
	localparam int HDR_ROOM = 5;

	arq_pkg::arq_state_e st_q;
	logic [31:0] sr_q;
	logic drop_q;
	logic [7:0] left_q;
	logic wr;
	logic [31:0] wdata;
	logic rd;
	logic [31:0] head;
	logic [AW:0] cnt;
	logic empty;
	logic full_pkt;
	logic acc;
	logic [3:0] stat;
	logic [31:0] rdmux;

	////////////////////////////////////////////////////////////////
	// Status code from the receive event; a pending ack on a response is done only in split mode
	function automatic logic [3:0] status_of(input logic [2:0] ev, input logic [3:0] ack,
			input logic resp, input logic [3:0] rc, input logic spl);
		logic [3:0] s;
		s = arq_pkg::ST_BADACK;
		case (ev)
			arq_pkg::EV_ACK: begin
				if (resp && rc != arq_pkg::RCODE_COMPLETE) begin
					s = arq_pkg::ST_RCODE; // see RULE18
				end else if (resp && ack == arq_pkg::ACK_PENDING) begin
					s = spl ? arq_pkg::ST_DONE : arq_pkg::ST_BADACK; // see RULE11 see RULE13
				end else if (ack == arq_pkg::ACK_COMPLETE || ack == arq_pkg::ACK_PENDING
						|| ack == arq_pkg::ACK_BUSY_X || ack == arq_pkg::ACK_BUSY_A
						|| ack == arq_pkg::ACK_BUSY_B) begin
					s = arq_pkg::ST_DONE; // see RULE11
				end else begin
					s = arq_pkg::ST_BADACK; // see RULE13
				end
			end
			arq_pkg::EV_NOACK: s = arq_pkg::ST_NOACK; // see RULE12
			arq_pkg::EV_ACKERR: s = arq_pkg::ST_MISSACK; // see RULE14
			arq_pkg::EV_BADNEXT: s = arq_pkg::ST_BADNEXT; // see RULE15
			arq_pkg::EV_FWDNEXT: s = arq_pkg::ST_FWDNEXT; // see RULE16
			arq_pkg::EV_RETRY: s = arq_pkg::ST_RETRY; // see RULE17
			default: s = arq_pkg::ST_BADACK;
		endcase
		return s;
	endfunction : status_of

	assign stat = status_of(rx_event_i, rx_ack_i, rx_is_resp_i, rx_rcode_i, split_en_o);
	assign empty = (cnt == '0);
	// Worst case header plus data must fit, so a packet is never split across a full store
	assign full_pkt = (32'(cnt) + HDR_ROOM + 32'(rx_nquad_i)) > DEPTH;
	assign acc = psel_i && penable_i;

	////////////////////////////////////////////////////////////////
	// Packet formatter
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_q <= arq_pkg::ARQ_IDLE;
			left_q <= '0;
			drop_q <= 1'b0;
		end else begin
			case (st_q)
				arq_pkg::ARQ_IDLE: begin
					drop_q <= 1'b0;
					if (rx_valid_i && !rx_ready_o) begin
						if (rx_to_agent_i || !sr_q[arq_pkg::SR_EN_BIT] || full_pkt) begin
							drop_q <= !rx_to_agent_i; // see RULE1
						end else begin
							st_q <= arq_pkg::ARQ_Q1; // see RULE1 see RULE2
						end
					end
				end
				arq_pkg::ARQ_Q1: st_q <= arq_pkg::ARQ_Q2;
				arq_pkg::ARQ_Q2: begin
					left_q <= rx_has_data_i ? (rx_block_i ? rx_nquad_i : 8'h01) : 8'h00;
					st_q <= arq_pkg::ARQ_Q3;
				end
				arq_pkg::ARQ_Q3: begin
					st_q <= (rx_block_i || left_q != 8'h00) ? arq_pkg::ARQ_Q4 : arq_pkg::ARQ_IDLE;
				end
				arq_pkg::ARQ_Q4: begin
					st_q <= rx_block_i ? arq_pkg::ARQ_Q5 : arq_pkg::ARQ_DATA; // see RULE9
				end
				arq_pkg::ARQ_Q5: begin
					st_q <= (left_q != 8'h00) ? arq_pkg::ARQ_DATA : arq_pkg::ARQ_IDLE;
				end
				arq_pkg::ARQ_DATA: begin
					left_q <= left_q - 8'h01;
					if (left_q == 8'h01) begin
						st_q <= arq_pkg::ARQ_IDLE; // see RULE8 see RULE10
					end
				end
				default: st_q <= arq_pkg::ARQ_IDLE;
			endcase
		end
	end

	// Quadlet being pushed in each state
	always_comb begin
		wr = 1'b1;
		wdata = '0;
		case (st_q)
			arq_pkg::ARQ_Q1: begin
				wdata[arq_pkg::TOK_STAT_LSB +: 4] = stat; // see RULE5 see RULE23
				wdata[arq_pkg::TOK_SPD_LSB +: 2] = rx_speed_i; // see RULE19
				wdata[arq_pkg::TOK_ACK_LSB +: 4] = rx_ack_i;
			end
			arq_pkg::ARQ_Q2: begin
				wdata = {rx_dst_bus_i, rx_dst_node_i, rx_tlabel_i, rx_retry_code_i,
					rx_tcode_i, 4'h0}; // see RULE6 see RULE20 see RULE21
			end
			arq_pkg::ARQ_Q3: begin
				if (rx_block_i) begin
					wdata = {rx_src_bus_i, rx_src_node_i, rx_offset_i[47:32]}; // see RULE9
				end else begin
					wdata = {rx_src_bus_i, rx_src_node_i, rx_rcode_i, 12'h000}; // see RULE7
				end
			end
			arq_pkg::ARQ_Q4: wdata = rx_block_i ? rx_offset_i[31:0] : 32'h0000_0000; // see RULE9
			arq_pkg::ARQ_Q5: wdata = {rx_len_i, rx_ext_tcode_i};
			arq_pkg::ARQ_DATA: wdata = rx_data_i; // see RULE8 see RULE10
			default: wr = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////
	// Handshake strobes back to the receive source
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rx_ready_o <= 1'b0;
			rx_data_take_o <= 1'b0;
		end else begin
			rx_data_take_o <= (st_q == arq_pkg::ARQ_DATA);
			rx_ready_o <= (st_q == arq_pkg::ARQ_IDLE && rx_valid_i && !rx_ready_o
					&& (rx_to_agent_i || !sr_q[arq_pkg::SR_EN_BIT] || full_pkt))
				|| ((st_q == arq_pkg::ARQ_Q3 && !rx_block_i && left_q == 8'h00)
				|| (st_q == arq_pkg::ARQ_Q5 && left_q == 8'h00)
				|| (st_q == arq_pkg::ARQ_DATA && left_q == 8'h01));
		end
	end

	////////////////////////////////////////////////////////////////
	arq_store #(
		.DEPTH(DEPTH),
		.AW(AW)
	) u_store (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.wr_i(wr),
		.wdata_i(wdata),
		.rd_i(rd),
		.rdata_o(head),
		.count_o(cnt)
	);

	////////////////////////////////////////////////////////////////
	// APB slave: one wait state per access, reads of a non-empty port pop one quadlet
	assign rd = acc && !pready_o && !pwrite_i && paddr_i == arq_pkg::ADDR_PORT && !empty; // see RULE3

	always_comb begin
		rdmux = '0;
		case (paddr_i)
			arq_pkg::ADDR_SPLIT: rdmux = {31'h0, split_en_o};
			arq_pkg::ADDR_STAT: begin
				rdmux[arq_pkg::SR_EN_BIT] = sr_q[arq_pkg::SR_EN_BIT]; // see RULE4
				rdmux[arq_pkg::SR_EMPTY_BIT] = empty;
				rdmux[arq_pkg::SR_FULL_BIT] = (cnt == (AW+1)'(DEPTH));
				rdmux[arq_pkg::SR_DROP_BIT] = sr_q[arq_pkg::SR_DROP_BIT];
				rdmux[arq_pkg::SR_CNT_LSB +: AW+1] = cnt;
			end
			arq_pkg::ADDR_PORT: rdmux = empty ? 32'h0000_0000 : head; // see RULE3 see RULE22
			default: rdmux = '0;
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pready_o <= 1'b0;
			prdata_o <= '0;
			pslverr_o <= 1'b0;
		end else begin
			pready_o <= acc && !pready_o;
			prdata_o <= rdmux;
			pslverr_o <= acc && !pready_o && !(paddr_i == arq_pkg::ADDR_SPLIT
				|| paddr_i == arq_pkg::ADDR_STAT || paddr_i == arq_pkg::ADDR_PORT);
		end
	end

	// Control registers; a drop sets the sticky bit and wins over a clear
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sr_q <= arq_pkg::SR_RESET;
			split_en_o <= 1'b0;
		end else begin
			if (acc && !pready_o && pwrite_i && paddr_i == arq_pkg::ADDR_SPLIT) begin
				split_en_o <= pwdata_i[0];
			end
			if (acc && !pready_o && pwrite_i && paddr_i == arq_pkg::ADDR_STAT) begin
				sr_q[arq_pkg::SR_EN_BIT] <= pwdata_i[arq_pkg::SR_EN_BIT]; // see RULE4
				if (pwdata_i[arq_pkg::SR_DROP_BIT]) begin
					sr_q[arq_pkg::SR_DROP_BIT] <= 1'b0;
				end
			end
			if (drop_q) begin
				sr_q[arq_pkg::SR_DROP_BIT] <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	sequence s_hdr;
		st_q == arq_pkg::ARQ_Q1 ##1 st_q == arq_pkg::ARQ_Q2 ##1 st_q == arq_pkg::ARQ_Q3;
	endsequence

	a_agent_skip: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // see RULE1
		(st_q == arq_pkg::ARQ_IDLE && rx_valid_i && rx_to_agent_i && !rx_ready_o)
			|=> st_q == arq_pkg::ARQ_IDLE)
		else $error("agent packet stored");
	a_header_order: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // see RULE5
		st_q == arq_pkg::ARQ_Q1 && $past(st_q) == arq_pkg::ARQ_IDLE |-> s_hdr)
		else $error("header sequence broken");
	a_token_stat: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // see RULE12
		(st_q == arq_pkg::ARQ_Q1 && rx_event_i == arq_pkg::EV_NOACK)
			|-> wr && wdata[31:28] == arq_pkg::ST_NOACK)
		else $error("no-ack status wrong");
	a_retry_stat: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // see RULE17
		(st_q == arq_pkg::ARQ_Q1 && rx_event_i == arq_pkg::EV_RETRY)
			|-> wdata[31:28] == 4'h7)
		else $error("retry status wrong");
	a_prio_zero: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // see RULE21
		st_q == arq_pkg::ARQ_Q2 |-> wdata[3:0] == 4'h0 && wdata[31:16] ==
			{rx_dst_bus_i, rx_dst_node_i})
		else $error("second quadlet wrong");
	a_quad_nodata: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // see RULE8
		(st_q == arq_pkg::ARQ_Q2 && !rx_block_i && !rx_has_data_i)
			|=> ##1 st_q == arq_pkg::ARQ_IDLE)
		else $error("data stored for dataless quadlet");
	a_port_pop: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // see RULE22
		(rd && !wr) |=> cnt == $past(cnt) - 1'b1)
		else $error("read did not advance");
	a_apb_ready: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // see RULE3
		(acc && !pready_o) |=> pready_o ##1 !pready_o)
		else $error("ready not one cycle");
	a_split_done: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // see RULE11
		(st_q == arq_pkg::ARQ_Q1 && rx_event_i == arq_pkg::EV_ACK && split_en_o
			&& rx_is_resp_i && rx_ack_i == arq_pkg::ACK_PENDING
			&& rx_rcode_i == arq_pkg::RCODE_COMPLETE) |-> wdata[31:28] == 4'h0)
		else $error("split status wrong");
endmodule : arq_top

// ---- arq_rx_src.sv ----
// Receive source model: offers one packet at a time and streams data quadlets.
// Assumes the testbench sets the packet fields before it calls offer.
`timescale 1ns/100ps
module arq_rx_src (
	input wire logic sys_clk_i, // Clock
	input wire logic rst_n_i, // Async reset, low
	input wire logic rx_ready_i, // Packet consumed pulse
	input wire logic rx_data_take_i, // Data quadlet consumed pulse
	output logic rx_valid_o, // Packet offered
	output logic [31:0] rx_data_o, // Current data quadlet
	output logic timeout_o // Offer never taken
);
	logic [31:0] idx_q;
	initial begin
		rx_valid_o = 1'h0;
		timeout_o = 1'h0;
	end
	////////////////////////////////////////////////////////////
	// A take means the shown quadlet is gone, so show the next one at once;
	// idle line shows the inverse so stale data cannot match
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			idx_q <= 32'h0;
		end else if (rx_data_take_i) begin
			idx_q <= idx_q + 32'h1;
		end
	end
	assign rx_data_o = rx_valid_o ? 32'hd000_0000 + idx_q + {31'h0, rx_data_take_i}
		: ~(32'hd000_0000 + idx_q);
	// Optional idle gap models a slow source
	task automatic offer(input int gap);
		int n;
		repeat (gap) @(posedge sys_clk_i);
		@(posedge sys_clk_i);
		rx_valid_o <= 1'h1;
		n = 0;
		do begin
			@(posedge sys_clk_i);
			n++;
		end while (rx_ready_i !== 1'h1 && n < 300);
		rx_valid_o <= 1'h0;
		if (n >= 300) begin
			timeout_o <= 1'h1;
		end
	endtask : offer
endmodule : arq_rx_src

// ---- tb_arq_top.sv ----
// Testbench for the receive packet queue: APB host tasks and status table.
// Assumes one APB wait state and the receive source model beside the design.
`timescale 1ns/100ps
module tb_arq_top;
	typedef struct {logic resp; logic [2:0] ev; logic [3:0] ack, rc; logic spl; logic [3:0] st;} arq_row_s;
	logic sys_clk_i = 1'h0, rst_n_i = 1'h0, psel_i = 1'h0, penable_i = 1'h0, pwrite_i = 1'h0;
	logic [11:0] paddr_i = 12'h0;
	logic [31:0] pwdata_i = 32'h0, prdata_o, rx_data_i, rd, exq [$];
	logic pready_o, pslverr_o, rx_valid_i, rx_ready_o, rx_data_take_o, split_en_o, err, src_to;
	logic rx_is_resp_i = 1'h0, rx_to_agent_i = 1'h0, rx_block_i = 1'h0, rx_has_data_i = 1'h0;
	logic [2:0] rx_event_i = 3'h0;
	logic [3:0] rx_ack_i = 4'h1, rx_tcode_i = 4'h6, rx_rcode_i = 4'h0;
	logic [1:0] rx_speed_i = 2'h0, rx_retry_code_i = 2'h2;
	logic [9:0] rx_dst_bus_i = 10'h155, rx_src_bus_i = 10'h0c3;
	logic [5:0] rx_dst_node_i = 6'h2a, rx_src_node_i = 6'h15, rx_tlabel_i = 6'h2d;
	logic [47:0] rx_offset_i = 48'h1234_5678_9abc;
	logic [15:0] rx_len_i = 16'h0008, rx_ext_tcode_i = 16'h0000;
	logic [7:0] rx_nquad_i = 8'h0;
	int miscompares = 0, check_count = 0, dq = 0;
	arq_row_s rows [11] = '{
		'{1'h1, arq_pkg::EV_ACK, arq_pkg::ACK_PENDING, 4'h0, 1'h1, 4'h0},
		'{1'h0, arq_pkg::EV_ACK, arq_pkg::ACK_COMPLETE, 4'h0, 1'h0, 4'h0},
		'{1'h0, arq_pkg::EV_ACK, arq_pkg::ACK_PENDING, 4'h0, 1'h1, 4'h0},
		'{1'h1, arq_pkg::EV_ACK, arq_pkg::ACK_PENDING, 4'h0, 1'h0, 4'h2},
		'{1'h0, arq_pkg::EV_ACK, 4'hd, 4'h0, 1'h0, 4'h2},
		'{1'h0, arq_pkg::EV_NOACK, 4'h0, 4'h0, 1'h0, 4'h1},
		'{1'h0, arq_pkg::EV_ACKERR, 4'h0, 4'h0, 1'h0, 4'h3},
		'{1'h0, arq_pkg::EV_BADNEXT, 4'h0, 4'h0, 1'h0, 4'h4},
		'{1'h0, arq_pkg::EV_FWDNEXT, 4'h0, 4'h0, 1'h0, 4'h5},
		'{1'h0, arq_pkg::EV_RETRY, 4'h0, 4'h0, 1'h0, 4'h7},
		'{1'h1, arq_pkg::EV_ACK, arq_pkg::ACK_COMPLETE, 4'h4, 1'h0, 4'h8}
	};
	arq_top u_dut (.sys_clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
		.prdata_o, .pready_o, .pslverr_o, .rx_valid_i, .rx_ready_o, .rx_is_resp_i, .rx_to_agent_i,
		.rx_block_i, .rx_has_data_i, .rx_event_i, .rx_ack_i, .rx_speed_i, .rx_dst_bus_i,
		.rx_dst_node_i, .rx_src_bus_i, .rx_src_node_i, .rx_tlabel_i, .rx_retry_code_i, .rx_tcode_i,
		.rx_rcode_i, .rx_offset_i, .rx_len_i, .rx_ext_tcode_i, .rx_nquad_i, .rx_data_i,
		.rx_data_take_o, .split_en_o);
	arq_rx_src u_src (.sys_clk_i, .rst_n_i, .rx_ready_i(rx_ready_o),
		.rx_data_take_i(rx_data_take_o), .rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i),
		.timeout_o(src_to));
	////////////////////////////////////////////////////////////
	// Clock, 4 ns period
	initial begin
		forever #2 sys_clk_i = ~sys_clk_i;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic end_of_test();
		if (miscompares == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : end_of_test
	// APB transfer; request held until pready is sampled high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		int n;
		@(posedge sys_clk_i);
		psel_i <= 1'h1;
		pwrite_i <= wr;
		paddr_i <= a;
		pwdata_i <= wd;
		@(posedge sys_clk_i);
		penable_i <= 1'h1;
		n = 0;
		do begin
			@(posedge sys_clk_i);
			n++;
		end while (pready_o !== 1'h1 && n < 50);
		rd = prdata_o;
		err = pslverr_o;
		psel_i <= 1'h0;
		penable_i <= 1'h0;
		if (n >= 50) miscompares++;
	endtask : apb
	// Offer a packet and queue the quadlets it should leave behind
	task automatic send(input logic resp, agt, blk, hd, input logic [2:0] ev,
		input logic [3:0] ack, rc, input logic [1:0] spd, input logic [7:0] nq,
		input logic [3:0] st, input logic keep, input int gap);
		int k;
		@(posedge sys_clk_i);
		rx_is_resp_i <= resp;
		rx_to_agent_i <= agt;
		rx_block_i <= blk;
		rx_has_data_i <= hd;
		rx_event_i <= ev;
		rx_ack_i <= ack;
		rx_rcode_i <= rc;
		rx_speed_i <= spd;
		rx_nquad_i <= nq;
		if (keep) begin
			exq.push_back({st, 10'h0, spd, 12'h0, ack});
			exq.push_back({rx_dst_bus_i, rx_dst_node_i, rx_tlabel_i, rx_retry_code_i, rx_tcode_i, 4'h0});
			if (blk) begin
				exq.push_back({rx_src_bus_i, rx_src_node_i, rx_offset_i[47:32]});
				exq.push_back(rx_offset_i[31:0]);
				exq.push_back({rx_len_i, rx_ext_tcode_i});
			end else begin
				exq.push_back({rx_src_bus_i, rx_src_node_i, rc, 12'h0});
				if (hd) exq.push_back(32'h0);
			end
			for (k = 0; hd && k < (blk ? int'(nq) : 1); k++) begin
				exq.push_back(32'hd000_0000 + 32'(dq));
				dq++;
			end
		end
		u_src.offer(gap);
	endtask : send
	// Read back every queued quadlet in arrival order
	task automatic drain();
		while (exq.size() > 0) begin
			apb(1'h0, arq_pkg::ADDR_PORT, 32'h0);
			chk(rd, exq.pop_front());
		end
	endtask : drain
	////////////////////////////////////////////////////////////
	// Main sequence: table rows, then hand-written cases
	initial begin
		repeat (6) @(posedge sys_clk_i);
		rst_n_i <= 1'h1;
		apb(1'h0, arq_pkg::ADDR_STAT, 32'h0);
		chk(rd, 32'h0000_0003);
		foreach (rows[i]) begin
			apb(1'h1, arq_pkg::ADDR_SPLIT, {31'h0, rows[i].spl});
			send(rows[i].resp, 1'h0, 1'h0, 1'h0, rows[i].ev, rows[i].ack, rows[i].rc,
				2'(i % 3), 8'h0, rows[i].st, 1'h1, i % 2);
			chk({31'h0, split_en_o}, {31'h0, rows[i].spl});
			drain();
		end
		// Back-to-back quadlet write, block write, block read request
		send(1'h0, 1'h0, 1'h0, 1'h1, arq_pkg::EV_ACK, 4'h1, 4'h0, 2'h2, 8'h0, 4'h0, 1'h1, 0);
		send(1'h0, 1'h0, 1'h1, 1'h1, arq_pkg::EV_ACK, 4'h1, 4'h0, 2'h1, 8'h2, 4'h0, 1'h1, 3);
		send(1'h0, 1'h0, 1'h1, 1'h0, arq_pkg::EV_ACK, 4'h1, 4'h0, 2'h0, 8'h2, 4'h0, 1'h1, 0);
		apb(1'h0, arq_pkg::ADDR_STAT, 32'h0);
		chk(rd, 32'h0000_1101);
		drain();
		// Agent request is skipped without a drop flag
		send(1'h0, 1'h1, 1'h0, 1'h0, arq_pkg::EV_ACK, 4'h1, 4'h0, 2'h0, 8'h0, 4'h0, 1'h0, 0);
		apb(1'h0, arq_pkg::ADDR_STAT, 32'h0);
		chk(rd, 32'h0000_0003);
		// Disabled queue drops, flag clears by writing one
		apb(1'h1, arq_pkg::ADDR_STAT, 32'h0);
		send(1'h0, 1'h0, 1'h0, 1'h0, arq_pkg::EV_ACK, 4'h1, 4'h0, 2'h0, 8'h0, 4'h0, 1'h0, 0);
		apb(1'h0, arq_pkg::ADDR_STAT, 32'h0);
		chk(rd, 32'h0000_000a);
		apb(1'h1, arq_pkg::ADDR_STAT, 32'h0000_0009);
		apb(1'h1, arq_pkg::ADDR_PORT, 32'h5a5a_5a5a);
		apb(1'h0, arq_pkg::ADDR_STAT, 32'h0);
		chk(rd, 32'h0000_0003);
		// Empty read port and an unmapped address
		apb(1'h0, arq_pkg::ADDR_PORT, 32'h0);
		chk(rd, 32'h0);
		apb(1'h0, 12'h0c4, 32'h0);
		chk({err, rd[30:0]}, 32'h8000_0000);
		chk({31'h0, src_to}, 32'h0);
		end_of_test();
	end
	// Watchdog well beyond the expected run length
	initial begin
		#200000;
		miscompares++;
		end_of_test();
	end
endmodule : tb_arq_top
